// ### rtl/nvm_pkg.sv
`default_nettype none
package nvm_pkg;
	// Register word indices; byte address is four times the index
	localparam logic [15:0] CTRL_INDEX = 16'h400A;
	localparam logic [15:0] KEY_INDEX = 16'h4008;
	localparam logic [15:0] STATUS_INDEX = 16'h4010;
	localparam logic [17:0] CTRL_ADDR = {CTRL_INDEX, 2'h0};
	localparam logic [17:0] KEY_ADDR = {KEY_INDEX, 2'h0};
	localparam logic [17:0] STATUS_ADDR = {STATUS_INDEX, 2'h0};
	localparam logic [15:0] UNLOCK_VALUE = 16'h9716;
	// Control field positions
	localparam int PROG_BIT = 15;
	localparam int MEM_BIT = 13;
	localparam int FINAL_BIT = 11;
	localparam int VERIFY_BIT = 10;
	localparam int WRITE_BIT = 9;
	localparam int READ_BIT = 8;
	localparam int MARGIN_LSB = 6;
	localparam int ALL_BIT = 5;
	localparam int PAGE_LSB = 0;
	// Reset values
	localparam logic MEM_RESET = 1'b1;
	localparam logic [1:0] MARGIN_RESET = 2'h0;
	localparam logic [1:0] PAGE_RESET = 2'h0;
	// Margin encodings
	localparam logic [1:0] MARGIN_NORMAL = 2'h0;
	localparam logic [1:0] MARGIN_RSVD = 2'h1;
	localparam logic [1:0] MARGIN_ONE = 2'h2;
	localparam logic [1:0] MARGIN_TWO = 2'h3;
	// Command codes on the memory port
	typedef enum logic [2:0] {
		CMD_NONE = 3'b000,
		CMD_READ = 3'b001,
		CMD_WRITE = 3'b010,
		CMD_VERIFY = 3'b011,
		CMD_FINAL = 3'b100
	} nvm_cmd_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ISSUE = 2'b01,
		ST_WAIT = 2'b10
	} ctl_state_t;
endpackage : nvm_pkg
`default_nettype wire

// ### rtl/nvm_program_control.sv
`default_nettype none
module nvm_program_control
	import nvm_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [17:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic program_state,
	output logic [2:0] mem_cmd,
	output logic mem_cmd_valid,
	output logic mem_emulation_sel,
	output logic mem_all_pages,
	output logic [2:0] mem_page,
	output logic [1:0] mem_margin,
	input wire logic mem_done,
	input wire logic mem_fail
);

	typedef struct packed {
		// Bus response
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		// Control register and lock
		logic unlocked;
		logic prog_state;
		logic mem_otp;
		logic finalised;
		logic [3:0] cmd_bits;
		logic [1:0] margin;
		logic all_pages;
		logic [1:0] page;
		// Command engine
		ctl_state_t state;
		logic [2:0] cmd;
		logic cmd_valid;
		logic last_fail;
		logic last_refused;
		// Held toward the memory engine from issue until the next command issues
		logic [2:0] page_out;
		logic emu_out;
		logic all_out;
		logic [1:0] margin_out;
	} state_t;

	typedef enum logic [1:0] {
		SEL_CTRL = 2'b00,
		SEL_KEY = 2'b01,
		SEL_STATUS = 2'b10,
		SEL_NONE = 2'b11
	} reg_sel_t;

	state_t s_reg;
	state_t s_next;

	// Page field to physical page, per target memory
	function automatic logic [2:0] page_map(input logic otp, input logic [1:0] code);
		if (otp) begin
			page_map = {1'b0, code};
		end else begin
			case (code)
				2'h0: begin
					page_map = 3'h2;
				end
				2'h1: begin
					page_map = 3'h3;
				end
				2'h2: begin
					page_map = 3'h4;
				end
				default: begin
					// Reserved code; refused before it can be issued
					page_map = 3'h0;
				end
			endcase
		end
	endfunction : page_map

	function automatic nvm_cmd_t pick_cmd(input logic [3:0] bits);
		if (bits[3]) begin
			pick_cmd = CMD_FINAL;
		end else if (bits[2]) begin
			pick_cmd = CMD_VERIFY;
		end else if (bits[1]) begin
			pick_cmd = CMD_WRITE;
		end else if (bits[0]) begin
			pick_cmd = CMD_READ;
		end else begin
			pick_cmd = CMD_NONE;
		end
	endfunction : pick_cmd

	// Command bits of a control write, highest priority first
	function automatic logic [3:0] cmd_field_of(input logic [15:0] word);
		cmd_field_of = {word[FINAL_BIT], word[VERIFY_BIT], word[WRITE_BIT], word[READ_BIT]};
	endfunction : cmd_field_of

	// Single-page commands to the emulation memory have no fourth page
	function automatic logic reserved_page(input logic otp, input logic all, input logic [1:0] code);
		reserved_page = !otp && !all && code == 2'h3;
	endfunction : reserved_page

	// Only whole-word addresses hit; anything else answers with an error
	function automatic reg_sel_t decode_reg(input logic [17:0] addr);
		case (addr)
			CTRL_ADDR: begin
				decode_reg = SEL_CTRL;
			end
			KEY_ADDR: begin
				decode_reg = SEL_KEY;
			end
			STATUS_ADDR: begin
				decode_reg = SEL_STATUS;
			end
			default: begin
				decode_reg = SEL_NONE;
			end
		endcase
	endfunction : decode_reg

	logic access;
	logic [15:0] ctrl_view;
	logic [15:0] wd;
	nvm_cmd_t want;
	logic refuse;
	reg_sel_t reg_sel;
	logic [15:0] status_view;
	logic [3:0] cmd_field;
	logic cmd_ready;
	logic otp_closed;
	logic page_reserved;
	logic emu_write;
	logic [2:0] issue_page;
	logic [1:0] issue_margin;

	assign access = psel && penable && !s_reg.pready;
	assign wd = pwdata[15:0];
	assign want = pick_cmd(s_reg.cmd_bits);
	assign reg_sel = decode_reg(paddr);
	assign cmd_field = cmd_field_of(wd);
	assign cmd_ready = s_reg.state == ST_IDLE && s_reg.cmd_bits == 4'h0;

	always_comb begin
		ctrl_view = 16'h0000;
		ctrl_view[PROG_BIT] = s_reg.prog_state;
		ctrl_view[MEM_BIT] = s_reg.mem_otp;
		ctrl_view[FINAL_BIT] = s_reg.cmd_bits[3];
		ctrl_view[VERIFY_BIT] = s_reg.cmd_bits[2];
		ctrl_view[WRITE_BIT] = s_reg.cmd_bits[1];
		ctrl_view[READ_BIT] = s_reg.cmd_bits[0];
		ctrl_view[MARGIN_LSB +: 2] = s_reg.margin;
		ctrl_view[ALL_BIT] = s_reg.all_pages;
		ctrl_view[PAGE_LSB +: 2] = s_reg.page;
	end

	// Status word: busy, finalised, last fail, last refused, unlocked, program state
	always_comb begin
		status_view = 16'h0000;
		status_view[0] = s_reg.prog_state;
		status_view[1] = s_reg.unlocked;
		status_view[2] = s_reg.last_refused;
		status_view[3] = s_reg.last_fail;
		status_view[4] = s_reg.finalised;
		status_view[5] = s_reg.state != ST_IDLE;
	end

	// Refuse OTP programming after finalise, emulation writes and the reserved emulation page.
	// A refused command still clears its bit, so software never waits on a command that cannot run.
	always_comb begin
		otp_closed = s_reg.finalised && s_reg.mem_otp && (want == CMD_WRITE || want == CMD_FINAL);
		page_reserved = reserved_page(s_reg.mem_otp, s_reg.all_pages, s_reg.page);
		emu_write = want == CMD_WRITE && !s_reg.mem_otp;
		refuse = otp_closed || page_reserved || emu_write;
	end

	// What an issued command carries to the engine
	always_comb begin
		if (s_reg.all_pages) begin
			issue_page = 3'h0;
		end else begin
			issue_page = page_map(s_reg.mem_otp, s_reg.page);
		end
		if (want == CMD_READ || want == CMD_VERIFY) begin
			issue_margin = s_reg.margin;
		end else begin
			// Write and finalise always sense at the normal level
			issue_margin = MARGIN_NORMAL;
		end
	end

	// Bus side answers with one wait state; the command engine below runs beside it

	always_comb begin
		s_next = s_reg;
		s_next.pready = 1'b0;
		s_next.pslverr = 1'b0;
		s_next.cmd_valid = 1'b0;
		if (access) begin
			s_next.pready = 1'b1;
			s_next.prdata = 32'h0000_0000;
			case (reg_sel)
				SEL_CTRL: begin
					if (pwrite) begin
						// Keyed fields ignored while locked; page and all-pages are open
						if (s_reg.unlocked) begin
							if (wd[PROG_BIT]) begin
								s_next.prog_state = 1'b1;
							end
							s_next.mem_otp = wd[MEM_BIT];
							s_next.margin = wd[MARGIN_LSB +: 2];
							// Commands latch only while idle; a busy write leaves them alone
							if (cmd_ready) begin
								s_next.cmd_bits = cmd_field;
							end
						end
						s_next.all_pages = wd[ALL_BIT];
						s_next.page = wd[PAGE_LSB +: 2];
					end else begin
						s_next.prdata = {16'h0000, ctrl_view};
					end
				end
				SEL_KEY: begin
					if (pwrite) begin
						// Any other value locks again, so a stray write cannot leave keyed fields open
						s_next.unlocked = (wd == UNLOCK_VALUE);
					end
				end
				SEL_STATUS: begin
					if (!pwrite) begin
						s_next.prdata = {16'h0000, status_view};
					end
				end
				default: begin
					s_next.pslverr = 1'b1;
				end
			endcase
		end
		// Command engine: one operation at a time, and a command bit
		// clears on completion or refusal, never while the engine still holds it
		case (s_reg.state)
			ST_IDLE: begin
				if (s_reg.cmd_bits != 4'h0) begin
					s_next.state = ST_ISSUE;
				end
			end
			ST_ISSUE: begin
				if (refuse) begin
					s_next.last_refused = 1'b1;
					s_next.cmd_bits = 4'h0;
					s_next.state = ST_IDLE;
				end else begin
					s_next.last_refused = 1'b0;
					s_next.cmd = want;
					s_next.cmd_valid = 1'b1;
					s_next.emu_out = !s_reg.mem_otp;
					s_next.all_out = s_reg.all_pages;
					s_next.page_out = issue_page;
					s_next.margin_out = issue_margin;
					s_next.state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (mem_done) begin
					s_next.last_fail = mem_fail;
					if (s_reg.cmd == CMD_FINAL && s_reg.emu_out == 1'b0 && !mem_fail) begin
						s_next.finalised = 1'b1;
					end
					s_next.cmd = CMD_NONE;
					s_next.cmd_bits = 4'h0;
					s_next.state = ST_IDLE;
				end
			end
			default: begin
				s_next.state = ST_IDLE;
			end
		endcase
		if (sys_rst) begin
			// Reset is the only way out of the program state
			s_next.prdata = 32'h0000_0000;
			s_next.pready = 1'b0;
			s_next.pslverr = 1'b0;
			s_next.unlocked = 1'b0;
			s_next.prog_state = 1'b0;
			s_next.mem_otp = MEM_RESET;
			s_next.finalised = 1'b0;
			s_next.cmd_bits = 4'h0;
			s_next.margin = MARGIN_RESET;
			s_next.all_pages = 1'b0;
			s_next.page = PAGE_RESET;
			s_next.state = ST_IDLE;
			s_next.cmd = CMD_NONE;
			s_next.cmd_valid = 1'b0;
			s_next.last_fail = 1'b0;
			s_next.last_refused = 1'b0;
			s_next.page_out = 3'h0;
			s_next.emu_out = 1'b0;
			s_next.all_out = 1'b0;
			s_next.margin_out = MARGIN_NORMAL;
		end
	end

	always_ff @(posedge clk) begin
		s_reg <= s_next;
	end

	assign prdata = s_reg.prdata;
	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;
	assign program_state = s_reg.prog_state;
	assign mem_cmd = s_reg.cmd;
	assign mem_cmd_valid = s_reg.cmd_valid;
	assign mem_emulation_sel = s_reg.emu_out;
	assign mem_all_pages = s_reg.all_out;
	assign mem_page = s_reg.page_out;
	assign mem_margin = s_reg.margin_out;

endmodule : nvm_program_control
`default_nettype wire

// ### tb/nvm_chk.sv
`default_nettype none
module nvm_chk
	import nvm_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic program_state,
	input wire logic [2:0] mem_cmd,
	input wire logic mem_cmd_valid,
	input wire logic mem_emulation_sel,
	input wire logic mem_all_pages,
	input wire logic [2:0] mem_page,
	input wire logic [1:0] mem_margin,
	input wire logic mem_done
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence busy_s;
		mem_cmd != 3'h0 && !mem_done;
	endsequence
	sequence single_s;
		mem_cmd_valid && !mem_all_pages;
	endsequence
	prog_sticky_a: assert property (program_state |=> program_state) else $error("program state dropped");
	cmd_hold_a: assert property (busy_s |=> $stable(mem_cmd) && $stable(mem_page)) else $error("cmd moved");
	cmd_clear_a: assert property (mem_cmd != 3'h0 && mem_done |=> mem_cmd == 3'h0) else $error("no clear");
	emu_write_a: assert property (mem_cmd_valid && mem_emulation_sel |-> mem_cmd != CMD_WRITE)
		else $error("emulation write issued");
	otp_page_a: assert property (single_s ##0 !mem_emulation_sel |-> mem_page < 3'h4) else $error("otp page");
	emu_page_a: assert property (single_s ##0 mem_emulation_sel |-> mem_page inside {[3'h2:3'h4]})
		else $error("emulation page");
	all_page_a: assert property (mem_cmd_valid && mem_all_pages |-> mem_page == 3'h0) else $error("all page");
	valid_pulse_a: assert property (mem_cmd_valid |-> mem_cmd != 3'h0 ##1 !mem_cmd_valid) else $error("pulse");
endmodule : nvm_chk
bind nvm_program_control nvm_chk chk_u (.clk, .sys_rst, .program_state, .mem_cmd, .mem_cmd_valid,
	.mem_emulation_sel, .mem_all_pages, .mem_page, .mem_margin, .mem_done);
`default_nettype wire

// ### tb/nvm_program_control_tb.sv
`default_nettype none
module nvm_program_control_tb;
	import nvm_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, mem_done = 1'b0;
	logic [17:0] paddr = 18'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic err = 1'b0;
	logic pready, pslverr, program_state, mem_cmd_valid, mem_emulation_sel, mem_all_pages;
	logic [2:0] mem_cmd, mem_page;
	logic [1:0] mem_margin;
	int num_errors = 0, cmp_count = 0, cyc = 0;
	nvm_program_control dut_u (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .program_state, .mem_cmd, .mem_cmd_valid, .mem_emulation_sel, .mem_all_pages, .mem_page,
		.mem_margin, .mem_done, .mem_fail(1'b0));
	always #5 clk = ~clk;
	// Engine answers one cycle after each command, so the next request finds it idle
	always @(posedge clk) mem_done <= mem_cmd != 3'h0 && !mem_done;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			num_errors++;
			end_sim();
		end
	end
	task automatic end_sim;
		$display("errors %0d comparisons %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
		rd = prdata;
		err = pslverr;
		if (n >= 20) begin
			num_errors++;
			$display("MISMATCH pready exp 1 got 0");
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic rdchk(input logic [17:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk("read", e, rd);
	endtask : rdchk
	// Expected word packs cmd, page, all pages, emulation select and margin
	task automatic go(input logic [15:0] d, input logic [31:0] e);
		int n;
		n = 0;
		apb(1'b1, CTRL_ADDR, {16'h0, d});
		while (mem_cmd_valid !== 1'b1 && n < 10) begin
			@(posedge clk);
			n++;
		end
		chk("issue", e, {22'h0, mem_cmd, mem_page, mem_all_pages, mem_emulation_sel, mem_margin});
	endtask : go
	task automatic nogo(input logic [15:0] d);
		int n;
		n = 0;
		apb(1'b1, CTRL_ADDR, {16'h0, d});
		repeat (8) begin
			@(posedge clk);
			n += int'(mem_cmd_valid === 1'b1);
		end
		chk("refused", 32'h0, n);
	endtask : nogo
	task t_reset;
		rdchk(CTRL_ADDR, 32'h2000);
		chk("prog", 32'h0, program_state);
		rdchk(18'h4, 32'h0);
		chk("slverr", 32'h1, err);
	endtask : t_reset
	task t_lock;
		nogo(16'h8100);
		rdchk(CTRL_ADDR, 32'h2000);
		chk("prog", 32'h0, program_state);
	endtask : t_lock
	task t_emu;
		apb(1'b1, KEY_ADDR, {16'h0, UNLOCK_VALUE});
		go(16'h0182, 32'h0C6);
		rdchk(CTRL_ADDR, 32'h0082);
		nogo(16'h0103);
		nogo(16'h0202);
	endtask : t_emu
	task t_otp;
		go(16'h24E0, 32'h18B);
		go(16'h2203, 32'h130);
		go(16'h2101, 32'h090);
	endtask : t_otp
	task t_final;
		go(16'h2800, 32'h200);
		nogo(16'h2200);
		rdchk(STATUS_ADDR, 32'h16);
	endtask : t_final
	task t_prog;
		apb(1'b1, CTRL_ADDR, 32'hA000);
		apb(1'b1, CTRL_ADDR, 32'h2000);
		chk("prog", 32'h1, program_state);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		chk("prog", 32'h0, program_state);
	endtask : t_prog
	initial begin
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_lock();
		t_emu();
		t_otp();
		t_final();
		t_prog();
		end_sim();
	end
endmodule : nvm_program_control_tb
`default_nettype wire
